//--- design/err_init_sideband.sv
// Purpose: floating-point error / break, internal fault, numeric-error ignore,
//          soft init and snoop stall sideband logic of the processor
// Assumes: pins other than CLK_SYS and RST_N are asynchronous; core side on CLK_SYS
// Notes: pins active low except RESET_VECTOR_STRAP and the OE outputs; open-drain outputs pull low while their OE is high
`timescale 1ns/1ns
`include "sideband_defs.svh"

module err_init_sideband (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // asynchronous pins
    input wire logic STOP_CLOCK_REQUEST_N,
    input wire logic INIT_N,
    input wire logic IGNORE_NUMERIC_FAULT_N,
    input wire logic HIT_IN_N,
    input wire logic SNOOP_HIT_MODIFIED_IN_N,
    input wire logic RESET_VECTOR_STRAP,
    // core side
    input wire sideband_pkg::core_req_s CORE_REQ,
    output sideband_pkg::core_rsp_s CORE_RSP,
    // output pins
    output logic FP_ERROR_BREAK_PENDING_N,
    output logic INTERNAL_FAULT_OUT_N,
    output logic HIT_OUT_N,
    output logic HIT_OE,
    output logic SNOOP_HIT_MODIFIED_OUT_N,
    output logic SNOOP_HIT_MODIFIED_OE
);
    import sideband_pkg::*;

    logic [`SYNC_WIDTH-1:0] pins_raw;
    logic [`SYNC_WIDTH-1:0] pins_s;
    logic stop_s;
    logic init_s;
    logic ignore_s;
    logic hit_s;
    logic snoop_hit_modified_s;
    logic vector_s;

    // pin polarity folded to active high before synchronising
    assign pins_raw[`PIN_STOP] = ~STOP_CLOCK_REQUEST_N;
    assign pins_raw[`PIN_INIT] = ~INIT_N;
    assign pins_raw[`PIN_IGNORE] = ~IGNORE_NUMERIC_FAULT_N;
    assign pins_raw[`PIN_HIT] = ~HIT_IN_N;
    assign pins_raw[`PIN_SNOOP_HIT_MODIFIED] = ~SNOOP_HIT_MODIFIED_IN_N;
    assign pins_raw[`PIN_VECTOR] = RESET_VECTOR_STRAP;

    pin_sync u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .d(pins_raw),
        .q(pins_s)
    );

    assign stop_s = pins_s[`PIN_STOP];
    assign init_s = pins_s[`PIN_INIT];
    assign ignore_s = pins_s[`PIN_IGNORE];
    assign hit_s = pins_s[`PIN_HIT];
    assign snoop_hit_modified_s = pins_s[`PIN_SNOOP_HIT_MODIFIED];
    assign vector_s = pins_s[`PIN_VECTOR];

    // error, fault and snoop-stall group
    logic pend_r, pend_nxt;
    logic fault_r, fault_nxt;
    logic internal_fault_out_n_r, internal_fault_out_n_nxt;
    logic ferr_n_r, ferr_n_nxt;
    logic stall_r, stall_nxt;
    logic stall_n_r, stall_n_nxt;
    logic exc_r, exc_nxt;
    logic shut_r, shut_nxt;
    logic seen_r, seen_nxt;
    logic ignore_eff;

    always_comb begin
        // set wins over clear
        pend_nxt = (pend_r & ~CORE_REQ.err_clear) | (CORE_REQ.err_event & ~CORE_REQ.err_masked);
        ignore_eff = ignore_s & ~CORE_REQ.native_ne;
        exc_nxt = CORE_REQ.instr_valid & pend_r & ~ignore_eff;
        if (stop_s) begin
            ferr_n_nxt = ~CORE_REQ.break_pending;
        end else begin
            ferr_n_nxt = ~pend_nxt;
        end
        fault_nxt = fault_r | CORE_REQ.fault_detect;
        internal_fault_out_n_nxt = ~fault_nxt;
        shut_nxt = CORE_REQ.fault_detect & ~fault_r;
        stall_nxt = CORE_REQ.snoop_stall_need;
        stall_n_nxt = ~CORE_REQ.snoop_stall_need;
        seen_nxt = hit_s & snoop_hit_modified_s;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pend_r <= 1'b0;
            fault_r <= 1'b0;
            internal_fault_out_n_r <= 1'b1;
            ferr_n_r <= 1'b1;
            stall_r <= 1'b0;
            stall_n_r <= 1'b1;
            exc_r <= 1'b0;
            shut_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            fault_r <= fault_nxt;
            internal_fault_out_n_r <= internal_fault_out_n_nxt;
            ferr_n_r <= ferr_n_nxt;
            stall_r <= stall_nxt;
            stall_n_r <= stall_n_nxt;
            exc_r <= exc_nxt;
            shut_r <= shut_nxt;
            seen_r <= seen_nxt;
        end
    end

    // init and self-test sequencing group
    seq_e seq_r, seq_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic vec_r, vec_nxt;
    logic regrst_r, regrst_nxt;
    logic resume_r, resume_nxt;
    logic bist_r, bist_nxt;
    logic snoop_en_r, snoop_en_nxt;

    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        vec_nxt = vec_r;
        regrst_nxt = 1'b0;
        resume_nxt = 1'b0;
        bist_nxt = 1'b0;
        snoop_en_nxt = 1'b1;
        case (seq_r)
            SEQ_SETTLE: begin
                // wait for the synchroniser to carry post-release pin levels
                snoop_en_nxt = 1'b0;
                if (cnt_r == `SETTLE_LAST) begin
                    vec_nxt = vector_s;
                    bist_nxt = init_s;
                    seq_nxt = init_s ? SEQ_INIT : SEQ_RUN;
                    regrst_nxt = init_s;
                    snoop_en_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + `SETTLE_STEP;
                end
            end
            SEQ_RUN: begin
                if (init_s) begin
                    regrst_nxt = 1'b1;
                    seq_nxt = SEQ_INIT;
                end
            end
            SEQ_INIT: begin
                if (init_s) begin
                    regrst_nxt = 1'b1;
                end else begin
                    resume_nxt = 1'b1;
                    seq_nxt = SEQ_RUN;
                end
            end
            default: begin
                seq_nxt = SEQ_SETTLE;
                cnt_nxt = `SETTLE_ZERO;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            seq_r <= SEQ_SETTLE;
            cnt_r <= `SETTLE_ZERO;
            vec_r <= 1'b0;
            regrst_r <= 1'b0;
            resume_r <= 1'b0;
            bist_r <= 1'b0;
            snoop_en_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
            vec_r <= vec_nxt;
            regrst_r <= regrst_nxt;
            resume_r <= resume_nxt;
            bist_r <= bist_nxt;
            snoop_en_r <= snoop_en_nxt;
        end
    end

    // caches and floating-point registers are never touched by init
    assign CORE_RSP.fp_exception = exc_r;
    assign CORE_RSP.shutdown_req = shut_r;
    assign CORE_RSP.int_reg_reset = regrst_r;
    assign CORE_RSP.resume = resume_r;
    assign CORE_RSP.resume_vec_sel = vec_r;
    assign CORE_RSP.bist_start = bist_r;
    assign CORE_RSP.snoop_enable = snoop_en_r;
    assign CORE_RSP.stall_seen = seen_r;
    assign FP_ERROR_BREAK_PENDING_N = ferr_n_r;
    assign INTERNAL_FAULT_OUT_N = internal_fault_out_n_r;
    assign HIT_OUT_N = stall_n_r;
    assign HIT_OE = stall_r;
    assign SNOOP_HIT_MODIFIED_OUT_N = stall_n_r;
    assign SNOOP_HIT_MODIFIED_OE = stall_r;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    a_ferr_error: assert property (!stop_s && CORE_REQ.err_event && !CORE_REQ.err_masked
        |=> !FP_ERROR_BREAK_PENDING_N)
        else $error("unmasked error not shown on error pin");
    a_ferr_break: assert property (stop_s |=> FP_ERROR_BREAK_PENDING_N == !$past(CORE_REQ.break_pending))
        else $error("break pending not shown while stop clock active");
    a_stall_pair: assert property (CORE_REQ.snoop_stall_need
        |=> HIT_OE && SNOOP_HIT_MODIFIED_OE && !HIT_OUT_N && !SNOOP_HIT_MODIFIED_OUT_N)
        else $error("snoop stall not driven on both pins");
    a_fault_raise: assert property (CORE_REQ.fault_detect && INTERNAL_FAULT_OUT_N
        |=> !INTERNAL_FAULT_OUT_N && CORE_RSP.shutdown_req ##1 !CORE_RSP.shutdown_req)
        else $error("fault not raised with one shutdown request");
    a_fault_hold: assert property (!INTERNAL_FAULT_OUT_N |=> !INTERNAL_FAULT_OUT_N)
        else $error("fault pin released before reset");
    a_ignore_exc: assert property (CORE_REQ.instr_valid && pend_r && ignore_s && !CORE_REQ.native_ne
        |=> !CORE_RSP.fp_exception)
        else $error("exception raised while numeric error ignored");
    a_raise_exc: assert property (CORE_REQ.instr_valid && pend_r && !ignore_s
        |=> CORE_RSP.fp_exception)
        else $error("pending numeric error not raised");
    a_native_override: assert property (CORE_REQ.instr_valid && pend_r && CORE_REQ.native_ne
        |=> CORE_RSP.fp_exception)
        else $error("ignore input honoured with native bit set");
    a_init_regs: assert property (seq_r != SEQ_SETTLE && init_s |=> CORE_RSP.int_reg_reset)
        else $error("integer registers not reset during init");
    a_init_resume: assert property (seq_r == SEQ_INIT && !init_s
        |=> CORE_RSP.resume && CORE_RSP.resume_vec_sel == $past(vec_r) ##1 !CORE_RSP.resume)
        else $error("no single resume at configured vector");
    a_init_snoop: assert property (init_s && seq_r != SEQ_SETTLE |=> CORE_RSP.snoop_enable [*2])
        else $error("snoop service stopped during init");
    a_bist_start: assert property (seq_r == SEQ_SETTLE && cnt_r == `SETTLE_LAST
        |=> CORE_RSP.bist_start == $past(init_s))
        else $error("self-test start does not follow init at release");

    c_fp_exception: cover property (CORE_REQ.err_event ##[1:20] CORE_RSP.fp_exception);
    c_break_event: cover property (stop_s && !FP_ERROR_BREAK_PENDING_N);
    c_init_cycle: cover property (CORE_RSP.int_reg_reset ##[1:50] CORE_RSP.resume);
    c_bist: cover property (CORE_RSP.bist_start);

endmodule

//--- design/pin_sync.sv
// Purpose: two-stage synchroniser for the asynchronous sideband pins
// Assumes: inputs are static levels compared with CLK_SYS
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
`include "sideband_defs.svh"

module pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [`SYNC_WIDTH-1:0] d,
    output logic [`SYNC_WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < `SYNC_WIDTH; i++) begin : g_bit
            // per-bit stages keep each flop owned by one process
            logic meta_r;
            logic q_r;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    q_r <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    q_r <= meta_r;
                end
            end
            assign q[i] = q_r;
        end
    endgenerate

    // outputs follow inputs by exactly two edges
    a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> q == $past(d, 2))
        else $error("synchroniser delay is not two cycles");

endmodule

//--- pkg/sideband_defs.svh
// Purpose: named constants for the error, init and snoop-stall sideband
// Assumes: included by the design files by its bare name
// Notes: bit positions index the synchronised pin vector
`ifndef SIDEBAND_DEFS_SVH
`define SIDEBAND_DEFS_SVH

`define SYNC_WIDTH 6
`define PIN_STOP 0
`define PIN_INIT 1
`define PIN_IGNORE 2
`define PIN_HIT 3
`define PIN_SNOOP_HIT_MODIFIED 4
`define PIN_VECTOR 5
`define SYNC_RESET_VAL 6'h00
`define SETTLE_LAST 2'h2
`define SETTLE_ZERO 2'h0
`define SETTLE_STEP 2'h1

`endif

//--- pkg/sideband_pkg.sv
// Purpose: types shared by the sideband block and its users
// Assumes: one bus clock domain
// Notes: core-side signals are active high; pins are active low except RESET_VECTOR_STRAP and the two OE outputs
package sideband_pkg;

    // requests from the execution core
    typedef struct packed {
        logic err_event;
        logic err_masked;
        logic err_clear;
        logic instr_valid;
        logic break_pending;
        logic native_ne;
        logic fault_detect;
        logic snoop_stall_need;
    } core_req_s;

    // answers to the execution core
    typedef struct packed {
        logic fp_exception;
        logic shutdown_req;
        logic int_reg_reset;
        logic resume;
        logic resume_vec_sel;
        logic bist_start;
        logic snoop_enable;
        logic stall_seen;
    } core_rsp_s;

    typedef enum logic [1:0] {
        SEQ_SETTLE,
        SEQ_RUN,
        SEQ_INIT
    } seq_e;

endpackage

//--- verif/chipset_model.sv
// Purpose: bus-side partner: pulled-up hit wires, another snooping agent, shutdown to nmi
// Assumes: released wires float high through the pull-up
// Notes: stall_req makes the other agent stall on both wires
`timescale 1ns/1ns
module chipset_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // device side
    input wire logic hit_oe,
    input wire logic hit_out_n,
    input wire logic snoop_hit_modified_oe,
    input wire logic snoop_hit_modified_out_n,
    input wire logic shutdown_req,
    // bench control
    input wire logic stall_req,
    // resolved wires and system error
    output logic hit_n,
    output logic snoop_hit_modified_n,
    output logic nmi
);
    // other agent always drives both wires together
    assign hit_n = ~((hit_oe & ~hit_out_n) | stall_req);
    assign snoop_hit_modified_n = ~((snoop_hit_modified_oe & ~snoop_hit_modified_out_n) | stall_req);
    // shutdown turned into an external error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi <= 1'b0;
        end else if (shutdown_req) begin
            nmi <= 1'b1;
        end
    end
endmodule

//--- verif/err_init_sideband_tb_top.sv
// Purpose: self-checking bench for the error, init and snoop-stall sideband
// Assumes: inputs driven 1 ns after the rising edge, outputs read there too
// Notes: cycle counts include the two-flop pin delay
`timescale 1ns/1ns
module err_init_sideband_tb_top;
    import sideband_pkg::*;
    logic CLK_SYS, RST_N, stop_n, init_n, ign_n, strap, agent;
    logic ferr_n, internal_fault_out_n, ho_n, hoe, mo_n, moe, hit_n, snoop_hit_modified_n, nmi;
    core_req_s req;
    core_rsp_s rsp;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    err_init_sideband dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .STOP_CLOCK_REQUEST_N(stop_n),
        .INIT_N(init_n), .IGNORE_NUMERIC_FAULT_N(ign_n), .HIT_IN_N(hit_n),
        .SNOOP_HIT_MODIFIED_IN_N(snoop_hit_modified_n), .RESET_VECTOR_STRAP(strap), .CORE_REQ(req),
        .CORE_RSP(rsp), .FP_ERROR_BREAK_PENDING_N(ferr_n), .INTERNAL_FAULT_OUT_N(internal_fault_out_n),
        .HIT_OUT_N(ho_n), .HIT_OE(hoe), .SNOOP_HIT_MODIFIED_OUT_N(mo_n),
        .SNOOP_HIT_MODIFIED_OE(moe));
    chipset_model part_u (.clk(CLK_SYS), .rst_n(RST_N), .hit_oe(hoe), .hit_out_n(ho_n),
        .snoop_hit_modified_oe(moe), .snoop_hit_modified_out_n(mo_n), .shutdown_req(rsp.shutdown_req),
        .stall_req(agent), .hit_n(hit_n), .snoop_hit_modified_n(snoop_hit_modified_n), .nmi(nmi));
    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    task cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task do_reset(input logic i, input logic s);
        RST_N = 1'b0;
        init_n = i;
        strap = s;
        cyc(12);
        RST_N = 1'b1;
    endtask
    // pulse one core request bit for one cycle
    task err_instr(input logic ex);
        req.instr_valid = 1'b1;
        cyc(1);
        req.instr_valid = 1'b0;
        chk(rsp.fp_exception, ex);
        cyc(1);
        chk(rsp.fp_exception, 1'b0);
    endtask
    task t_err;
        req.err_event = 1'b1;
        req.err_masked = 1'b1;
        cyc(1);
        req.err_event = 1'b0;
        req.err_masked = 1'b0;
        cyc(1);
        chk(ferr_n, 1'b1);
        err_instr(1'b0);
        req.err_event = 1'b1;
        cyc(1);
        req.err_event = 1'b0;
        chk(ferr_n, 1'b0);
        err_instr(1'b1);
        cyc(1);
        chk(rsp.fp_exception, 1'b0);
    endtask
    task t_ignore;
        ign_n = 1'b0;
        cyc(3);
        err_instr(1'b0);
        chk(ferr_n, 1'b0);
        req.native_ne = 1'b1;
        err_instr(1'b1);
        req.native_ne = 1'b0;
        ign_n = 1'b1;
        cyc(3);
        err_instr(1'b1);
        req.err_clear = 1'b1;
        cyc(1);
        req.err_clear = 1'b0;
        err_instr(1'b0);
        chk(ferr_n, 1'b1);
        // event and clear together: set wins
        req.err_event = 1'b1;
        req.err_clear = 1'b1;
        cyc(1);
        req.err_event = 1'b0;
        chk(ferr_n, 1'b0);
        cyc(1);
        req.err_clear = 1'b0;
        chk(ferr_n, 1'b1);
    endtask
    task t_break;
        stop_n = 1'b0;
        req.break_pending = 1'b1;
        cyc(3);
        chk(ferr_n, 1'b0);
        req.break_pending = 1'b0;
        cyc(1);
        chk(ferr_n, 1'b1);
        stop_n = 1'b1;
        cyc(3);
    endtask
    task t_fault;
        req.fault_detect = 1'b1;
        cyc(1);
        req.fault_detect = 1'b0;
        chk({internal_fault_out_n, rsp.shutdown_req}, 2'h1);
        cyc(1);
        chk(rsp.shutdown_req, 1'b0);
        chk(nmi, 1'b1);
        req.fault_detect = 1'b1;
        cyc(1);
        req.fault_detect = 1'b0;
        chk(rsp.shutdown_req, 1'b0);
        cyc(20);
        chk(internal_fault_out_n, 1'b0);
    endtask
    task t_stall;
        req.snoop_stall_need = 1'b1;
        cyc(1);
        chk({hoe, moe, ho_n, mo_n}, 4'hc);
        cyc(3);
        chk(rsp.stall_seen, 1'b1);
        req.snoop_stall_need = 1'b0;
        cyc(1);
        chk({hoe, moe}, 2'h0);
        agent = 1'b1;
        cyc(4);
        chk({rsp.stall_seen, hoe, moe}, 3'h4);
        agent = 1'b0;
        cyc(4);
        chk(rsp.stall_seen, 1'b0);
    endtask
    task t_init(input logic vec);
        init_n = 1'b0;
        cyc(3);
        chk({rsp.int_reg_reset, rsp.snoop_enable}, 2'h3);
        cyc(2);
        init_n = 1'b1;
        chk(rsp.snoop_enable, 1'b1);
        cyc(3);
        chk({rsp.int_reg_reset, rsp.resume}, 2'h1);
        chk(rsp.resume_vec_sel, vec);
        cyc(1);
        chk(rsp.resume, 1'b0);
    endtask
    task t_bist;
        do_reset(1'b0, 1'b1);
        chk({internal_fault_out_n, ferr_n, rsp}, 10'h300);
        cyc(3);
        chk({rsp.bist_start, rsp.int_reg_reset}, 2'h3);
        cyc(1);
        chk(rsp.bist_start, 1'b0);
        init_n = 1'b1;
        cyc(3);
        chk({rsp.int_reg_reset, rsp.resume, rsp.resume_vec_sel}, 3'h3);
    endtask
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        {stop_n, ign_n, agent} = 3'h6;
        req = '0;
        do_reset(1'b1, 1'b0);
        cyc(5);
        t_err();
        t_ignore();
        t_break();
        t_stall();
        t_init(1'b0);
        t_fault();
        t_bist();
        end_sim();
    end
endmodule
